// File: inc/dso_pkg.sv
/*
 * Shared constants and types of the drive status output selector.
 * Assumes one 10 MHz drive control clock for every user of the package.
 */
`default_nettype none
package dso_pkg;
  // Clock and timing; the limiting times are in milliseconds.
  localparam int CLK_HZ         = 10_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int CYC_PER_MS     = CLK_HZ / MS_PER_S;
  localparam int LIMIT_HOLD_MS  = 100;
  localparam int LIMIT_DELAY_MS = 20;
  localparam int MS_CNT_W       = 16;
  localparam int LIM_CNT_W      = 8;
  // Register port.
  localparam int ADDR_W     = 4;
  localparam int DATA_W     = 16;
  localparam int CODE_W     = 11;
  localparam int TERM_COUNT = 5;
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_START_FREQ = 4'h1;
  localparam logic [3:0] REG_STOP_FREQ  = 4'h2;
  localparam logic [3:0] REG_UV_LEVEL   = 4'h3;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam logic [3:0] REG_TERM_BASE  = 4'h8;
  // Control register fields.
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_KEYPAD_BIT = 3;
  localparam logic [2:0] MODE_VF     = 3'h0;
  localparam logic [2:0] MODE_PG_VF  = 3'h1;
  localparam logic [2:0] MODE_NO_PG  = 3'h2;
  localparam logic [2:0] MODE_PG     = 3'h3;
  localparam logic [2:0] MODE_TORQUE = 3'h4;
  // Reset values.
  localparam logic [15:0] CTRL_RST       = 16'h0000;
  localparam logic [15:0] START_FREQ_RST = 16'h0005;
  localparam logic [15:0] STOP_FREQ_RST  = 16'h0002;
  localparam logic [15:0] UV_LEVEL_RST   = 16'h00C8;
  localparam logic [10:0] TERM_CFG_RST   = 11'h7FF;
  // Function codes.
  localparam logic [10:0] INV_OFFSET     = 11'h3E8;
  localparam logic [10:0] FC_RUN         = 11'h000;
  localparam logic [10:0] FC_UNDERVOLT   = 11'h003;
  localparam logic [10:0] FC_TORQUE_POL  = 11'h004;
  localparam logic [10:0] FC_LIMIT       = 11'h005;
  localparam logic [10:0] FC_KEYPAD      = 11'h008;
  localparam logic [10:0] FC_READY       = 11'h00A;
  localparam logic [10:0] FC_LINE_SW_A   = 11'h00B;
  localparam logic [10:0] FC_LINE_SW_C   = 11'h00D;
  localparam logic [10:0] FC_CONTACTOR   = 11'h00F;
  localparam logic [10:0] FC_LIMIT_DLY   = 11'h016;
  localparam logic [10:0] FC_OUT_ACTIVE  = 11'h023;
  localparam logic [10:0] FC_MOTOR1      = 11'h030;
  localparam logic [10:0] FC_MOTOR4      = 11'h033;
  localparam logic [10:0] FC_FWD_RUNNING = 11'h034;
  localparam logic [10:0] FC_REV_RUNNING = 11'h035;
  localparam logic [10:0] FC_REMOTE      = 11'h036;
  localparam logic [10:0] FC_THERMISTOR  = 11'h038;
  localparam logic [10:0] FC_ARRIVAL     = 11'h048;
  localparam logic [10:0] FC_ANY_ALARM   = 11'h063;
  localparam logic [10:0] FC_CUSTOM1     = 11'h06F;
  localparam logic [10:0] FC_CUSTOM5     = 11'h073;

  typedef enum logic [1:0] {
    CT_OFF,
    CT_ON,
    CT_STOPPING
  } dso_ct_state_type;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dso_bus_req_type;

  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] dc_volt;
    logic        torque_braking;
    logic        dc_braking;
    logic        dew_prevent;
    logic        pre_exciting;
    logic        zero_speed;
    logic        servo_lock;
    logic [3:0]  limit_actions;
    logic        hw_prep_done;
    logic        protect_active;
    logic        uv_trip;
    logic        forward_run_command;
    logic        stop_cmd;
    logic        coast_cmd;
    logic        alarm;
    logic        motor_stopped;
    logic [1:0]  motor_sel;
    logic        forward_running_flag;
    logic        reverse_running_flag;
    logic        remote_mode_flag;
    logic        thermistor_overheat_flag;
    logic        arrival_window_flag;
    logic [4:0]  custom_logic_out;
  } dso_drive_in_type;

  typedef struct packed {
    logic run_flag;
    logic output_active_flag;
    logic undervoltage_flag;
    logic torque_pol_flag;
    logic output_limit_flag;
    logic delayed_limit_flag;
    logic keypad_source_flag;
    logic ready_flag;
    logic mains_contactor_ctrl;
  } dso_flags_type;
endpackage
`default_nettype wire

// File: hdl/dso_selector.sv
/*
 * Drive status flag derivation and routing to the digital output
 * terminals, with a small register port for configuration.
 * Assumes every drive input comes from logic on the same 10 MHz clock
 * and that the register master never issues both strobes at once.
 */
// What this block does
// - Terminal shows flag for base code, inverted for code plus 1000.
// - Running and output-active flags follow start/stop frequency hysteresis.
// - Running flag is off during DC braking and dew prevention.
// - Output-active stays on in DC braking, pre-exciting, zero speed, dew.
// - Vector control with zero speed or servo-lock sets both run flags.
// - Undervoltage flag follows DC link voltage against configured level.
// - Undervoltage flag also holds during an undervoltage trip stop.
// - Run commands are ignored while undervoltage flag is on.
// - Torque polarity flag is low when driving, high when braking.
// - Output-limit flag follows any limiting, each pulse at least 100 ms.
// - Delayed limit flag needs 20 ms of continuous limiting.
// - Torque, software current, hardware current, anti-regen all count.
// - Keypad-source flag follows keypad selected as run source.
// - Ready flag needs preparation done and no protection active.
// - Contactor control on with forward run, off after stop decel.
// - Contactor control off at once on coast stop or alarm.
// - Arrival window code 72 is inactive under torque control.
// - Codes 111 to 115 route the five custom logic outputs.
// - Codes 52, 56, 99 select forward running, thermistor, any alarm.
`default_nettype none
module dso_selector #(
  parameter int P_CYC_PER_MS     = dso_pkg::CYC_PER_MS,
  parameter int P_LIMIT_HOLD_MS  = dso_pkg::LIMIT_HOLD_MS,
  parameter int P_LIMIT_DELAY_MS = dso_pkg::LIMIT_DELAY_MS
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_resetn,
  input  wire dso_pkg::dso_bus_req_type        i_bus,
  output logic [dso_pkg::DATA_W-1:0]           o_rdata,
  input  wire dso_pkg::dso_drive_in_type       i_drive,
  output logic [dso_pkg::TERM_COUNT-1:0]       o_term,
  output logic                                 o_run_accept,
  output dso_pkg::dso_flags_type               o_flags
);
  import dso_pkg::*;

  typedef struct packed {
    logic [15:0]                      ctrl;
    logic [15:0]                      start_freq;
    logic [15:0]                      stop_freq;
    logic [15:0]                      uv_level;
    logic [TERM_COUNT-1:0][CODE_W-1:0] term_cfg;
    logic [DATA_W-1:0]                rdata;
    logic                             run_core;
    logic                             uv_core;
    logic [MS_CNT_W-1:0]              ms_cnt;
    logic [LIM_CNT_W-1:0]             hold_cnt;
    logic [LIM_CNT_W-1:0]             dly_cnt;
    dso_ct_state_type                 ct_state;
    dso_flags_type                    flags;
    logic [TERM_COUNT-1:0]            term;
    logic                             run_accept;
  } dso_state_type;

  localparam logic [MS_CNT_W-1:0] MS_LAST =
    MS_CNT_W'(P_CYC_PER_MS - 1);
  localparam logic [LIM_CNT_W-1:0] HOLD_TICKS =
    LIM_CNT_W'(P_LIMIT_HOLD_MS);
  localparam logic [LIM_CNT_W-1:0] DELAY_TICKS =
    LIM_CNT_W'(P_LIMIT_DELAY_MS);

  dso_state_type state_reg;
  dso_state_type state_next;

  // Codes whose negative-logic form does not exist are refused.
  function automatic logic code_allowed(input logic [CODE_W-1:0] code);
    logic [CODE_W-1:0] base;
    base = code - INV_OFFSET;
    code_allowed = 1'b1;
    if (code >= INV_OFFSET && base >= FC_LINE_SW_A &&
        base <= FC_LINE_SW_C) begin
      code_allowed = 1'b0;
    end
  endfunction

  function automatic logic select_flag(
    input logic [CODE_W-1:0] code,
    input dso_flags_type     fl,
    input dso_drive_in_type  dr,
    input logic              torque_mode
  );
    logic              inv;
    logic              ok;
    logic              f;
    logic [CODE_W-1:0] base;
    inv = (code >= INV_OFFSET);
    base = inv ? code - INV_OFFSET : code;
    ok = 1'b1;
    f = 1'b0;
    case (base)
      FC_RUN:         f = fl.run_flag;
      FC_UNDERVOLT:   f = fl.undervoltage_flag;
      FC_TORQUE_POL:  f = fl.torque_pol_flag;
      FC_LIMIT:       f = fl.output_limit_flag;
      FC_KEYPAD:      f = fl.keypad_source_flag;
      FC_READY:       f = fl.ready_flag;
      FC_CONTACTOR:   f = fl.mains_contactor_ctrl;
      FC_LIMIT_DLY:   f = fl.delayed_limit_flag;
      FC_OUT_ACTIVE:  f = fl.output_active_flag;
      FC_FWD_RUNNING: f = dr.forward_running_flag;
      FC_REV_RUNNING: f = dr.reverse_running_flag;
      FC_REMOTE:      f = dr.remote_mode_flag;
      FC_THERMISTOR:  f = dr.thermistor_overheat_flag;
      FC_ANY_ALARM:   f = dr.alarm;
      FC_ARRIVAL: begin
        f = dr.arrival_window_flag;
        ok = !torque_mode;
      end
      default: begin
        if (base >= FC_MOTOR1 && base <= FC_MOTOR4) begin
          f = (dr.motor_sel == 2'(base - FC_MOTOR1));
        end else if (base >= FC_CUSTOM1 && base <= FC_CUSTOM5) begin
          f = dr.custom_logic_out[3'(base - FC_CUSTOM1)];
        end else begin
          ok = 1'b0;
        end
      end
    endcase
    if (!ok || !code_allowed(code)) begin
      select_flag = 1'b0;
    end else begin
      select_flag = f ^ inv;
    end
  endfunction

  always_comb begin
    logic              tick;
    logic              lim_any;
    logic              vec_hold;
    logic [2:0]        mode;
    logic [CODE_W-1:0] wcode;
    logic [ADDR_W-1:0] tidx;
    state_next = state_reg;
    tick = 1'b0;
    lim_any = 1'b0;
    vec_hold = 1'b0;
    mode = state_reg.ctrl[CTRL_MODE_LSB +: 3];
    wcode = i_bus.wdata[CODE_W-1:0];
    tidx = i_bus.addr - REG_TERM_BASE;

    // Register writes.
    if (i_bus.wr) begin
      case (i_bus.addr)
        REG_CTRL:       state_next.ctrl = i_bus.wdata;
        REG_START_FREQ: state_next.start_freq = i_bus.wdata;
        REG_STOP_FREQ:  state_next.stop_freq = i_bus.wdata;
        REG_UV_LEVEL:   state_next.uv_level = i_bus.wdata;
        default: begin
          if (i_bus.addr >= REG_TERM_BASE &&
              tidx < ADDR_W'(TERM_COUNT) &&
              code_allowed(wcode)) begin
            state_next.term_cfg[tidx] = wcode;
          end
        end
      endcase
    end

    // Register reads; the data stand only in the following cycle.
    state_next.rdata = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        REG_CTRL:       state_next.rdata = state_reg.ctrl;
        REG_START_FREQ: state_next.rdata = state_reg.start_freq;
        REG_STOP_FREQ:  state_next.rdata = state_reg.stop_freq;
        REG_UV_LEVEL:   state_next.rdata = state_reg.uv_level;
        REG_STATUS: begin
          state_next.rdata = DATA_W'({state_reg.term,
                                      state_reg.run_accept,
                                      state_reg.flags});
        end
        default: begin
          if (i_bus.addr >= REG_TERM_BASE &&
              tidx < ADDR_W'(TERM_COUNT)) begin
            state_next.rdata =
              DATA_W'(state_reg.term_cfg[tidx]);
          end
        end
      endcase
    end

    // Millisecond enable pulse for the limiting timers.
    tick = (state_reg.ms_cnt == MS_LAST);
    state_next.ms_cnt = tick ? '0 : state_reg.ms_cnt + 1'b1;

    // Frequency hysteresis shared by both running flags.
    if (i_drive.out_freq > state_reg.start_freq) begin
      state_next.run_core = 1'b1;
    end else if (i_drive.out_freq < state_reg.stop_freq) begin
      state_next.run_core = 1'b0;
    end
    vec_hold = (mode == MODE_NO_PG || mode == MODE_PG) &&
               (i_drive.zero_speed || i_drive.servo_lock);
    state_next.flags.run_flag = vec_hold ||
      (state_reg.run_core && !i_drive.dc_braking &&
       !i_drive.dew_prevent);
    state_next.flags.output_active_flag = vec_hold ||
      state_reg.run_core || i_drive.dc_braking ||
      i_drive.pre_exciting || i_drive.zero_speed ||
      i_drive.dew_prevent;

    // Undervoltage with the level as the switching point.
    if (i_drive.dc_volt < state_reg.uv_level) begin
      state_next.uv_core = 1'b1;
    end else if (i_drive.dc_volt > state_reg.uv_level) begin
      state_next.uv_core = 1'b0;
    end
    state_next.flags.undervoltage_flag =
      state_reg.uv_core || i_drive.uv_trip;

    state_next.flags.torque_pol_flag = i_drive.torque_braking;

    // Limiting: the hold counter runs from the flag's rising edge so a
    // short burst still gives a pulse of the full minimum width.
    lim_any = |i_drive.limit_actions;
    if (!state_reg.flags.output_limit_flag) begin
      state_next.hold_cnt = '0;
      state_next.flags.output_limit_flag = lim_any;
    end else begin
      if (tick && state_reg.hold_cnt <= HOLD_TICKS) begin
        state_next.hold_cnt = state_reg.hold_cnt + 1'b1;
      end
      if (!lim_any && state_reg.hold_cnt > HOLD_TICKS) begin
        state_next.flags.output_limit_flag = 1'b0;
      end
    end
    // One spare tick absorbs the unknown phase of the first pulse.
    if (!lim_any) begin
      state_next.dly_cnt = '0;
    end else if (tick && state_reg.dly_cnt <= DELAY_TICKS) begin
      state_next.dly_cnt = state_reg.dly_cnt + 1'b1;
    end
    state_next.flags.delayed_limit_flag =
      lim_any && (state_reg.dly_cnt > DELAY_TICKS);

    state_next.flags.keypad_source_flag =
      state_reg.ctrl[CTRL_KEYPAD_BIT];
    state_next.flags.ready_flag =
      i_drive.hw_prep_done && !i_drive.protect_active;

    // Run command gating and the mains contactor sequence.
    state_next.run_accept = i_drive.forward_run_command &&
      !state_reg.flags.undervoltage_flag;
    case (state_reg.ct_state)
      CT_OFF: begin
        if (state_reg.run_accept) begin
          state_next.ct_state = CT_ON;
        end
      end
      CT_ON: begin
        if (i_drive.stop_cmd) begin
          state_next.ct_state = CT_STOPPING;
        end
      end
      CT_STOPPING: begin
        if (state_reg.run_accept) begin
          state_next.ct_state = CT_ON;
        end else if (i_drive.motor_stopped) begin
          state_next.ct_state = CT_OFF;
        end
      end
      default: state_next.ct_state = CT_OFF;
    endcase
    if (i_drive.coast_cmd || i_drive.alarm) begin
      state_next.ct_state = CT_OFF;
    end
    state_next.flags.mains_contactor_ctrl =
      (state_next.ct_state != CT_OFF);

    // Terminal routing uses the registered flags.
    for (int t = 0; t < TERM_COUNT; t++) begin
      state_next.term[t] = select_flag(state_reg.term_cfg[t],
        state_reg.flags, i_drive, mode == MODE_TORQUE);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg            <= '0;
      state_reg.ctrl       <= CTRL_RST;
      state_reg.start_freq <= START_FREQ_RST;
      state_reg.stop_freq  <= STOP_FREQ_RST;
      state_reg.uv_level   <= UV_LEVEL_RST;
      state_reg.term_cfg   <= {TERM_COUNT{TERM_CFG_RST}};
      state_reg.ct_state   <= CT_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata      = state_reg.rdata;
  assign o_term       = state_reg.term;
  assign o_run_accept = state_reg.run_accept;
  assign o_flags      = state_reg.flags;
endmodule
`default_nettype wire

// File: bench/dso_selector_props.sv
/*
 * Concurrent checks on the status output selector ports.
 * Assumes one clock and an active-low asynchronous reset.
 */
`default_nettype none
module dso_selector_props #(
  parameter int P_CYC_PER_MS     = dso_pkg::CYC_PER_MS,
  parameter int P_LIMIT_HOLD_MS  = dso_pkg::LIMIT_HOLD_MS,
  parameter int P_LIMIT_DELAY_MS = dso_pkg::LIMIT_DELAY_MS
) (
  input wire logic                      i_clk,
  input wire logic                      i_resetn,
  input wire dso_pkg::dso_drive_in_type i_drive,
  input wire logic                      o_run_accept,
  input wire dso_pkg::dso_flags_type    o_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  import dso_pkg::*;
  localparam int HOLD_CYC = P_LIMIT_HOLD_MS * P_CYC_PER_MS;
  localparam int DLY_CYC  = P_LIMIT_DELAY_MS * P_CYC_PER_MS;
  logic [31:0] hi_cnt_reg;
  logic [31:0] act_cnt_reg;
  // Streak counters keep the long limits out of repetition operators.
  // They are wide enough for the full-rate millisecond count as well.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hi_cnt_reg  <= 32'h00000000;
      act_cnt_reg <= 32'h00000000;
    end else begin
      hi_cnt_reg  <= o_flags.output_limit_flag ? hi_cnt_reg + 32'h00000001
                                               : 32'h00000000;
      act_cnt_reg <= (|i_drive.limit_actions) ? act_cnt_reg + 32'h00000001
                                              : 32'h00000000;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_uv_blocks_run: assert property (
    o_flags.undervoltage_flag && $past(o_flags.undervoltage_flag)
    |-> !o_run_accept) else $error("run accepted in undervoltage");
  a_uv_trip_holds: assert property (
    i_drive.uv_trip |-> ##[1:2] o_flags.undervoltage_flag)
    else $error("undervoltage flag missing during trip");
  a_torque_pol_follow: assert property (
    1'b1 |=> o_flags.torque_pol_flag == $past(i_drive.torque_braking))
    else $error("torque polarity flag wrong");
  a_ready_needs_prep: assert property (
    1'b1 |=> o_flags.ready_flag ==
      $past(i_drive.hw_prep_done && !i_drive.protect_active))
    else $error("ready flag wrong");
  a_limit_any_action: assert property (
    |i_drive.limit_actions |=> o_flags.output_limit_flag)
    else $error("limit flag missing while limiting");
  a_limit_min_width: assert property (
    $fell(o_flags.output_limit_flag) |-> hi_cnt_reg >= HOLD_CYC)
    else $error("limit flag pulse too short");
  a_delay_limit_wait: assert property (
    $rose(o_flags.delayed_limit_flag) |-> act_cnt_reg >= DLY_CYC)
    else $error("delayed limit flag too early");
  a_contactor_on: assert property (
    o_run_accept && !i_drive.coast_cmd && !i_drive.alarm
    |=> o_flags.mains_contactor_ctrl) else $error("contactor not on");
  a_contactor_drop: assert property (
    i_drive.coast_cmd || i_drive.alarm |=> !o_flags.mains_contactor_ctrl)
    else $error("contactor not dropped");
  cover property ($rose(o_flags.mains_contactor_ctrl));
  cover property ($rose(o_flags.delayed_limit_flag));
  cover property ($fell(o_flags.output_limit_flag));
endmodule
bind dso_selector dso_selector_props #(
  .P_CYC_PER_MS     (P_CYC_PER_MS),
  .P_LIMIT_HOLD_MS  (P_LIMIT_HOLD_MS),
  .P_LIMIT_DELAY_MS (P_LIMIT_DELAY_MS)
) props_u (
  .i_clk        (i_clk),
  .i_resetn     (i_resetn),
  .i_drive      (i_drive),
  .o_run_accept (o_run_accept),
  .o_flags      (o_flags)
);
`default_nettype wire

// File: bench/dso_relay_bank.sv
/*
 * Relay bank wired to the output terminals, as external equipment.
 * Assumes the terminal levels are sampled on the drive control clock.
 */
`default_nettype none
module dso_relay_bank #(
  parameter int P_PICKUP = 2
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic [4:0] i_coil,
  output logic      [4:0] o_contact
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] last_reg;
  int         stable;
  // Contacts move only after the coil is steady, so glitches never pass.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_reg  <= 5'h00;
      stable    <= 0;
      o_contact <= 5'h00;
    end else begin
      last_reg <= i_coil;
      stable   <= (i_coil == last_reg) ? stable + 1 : 0;
      if (stable >= P_PICKUP) o_contact <= last_reg;
    end
  end
endmodule
`default_nettype wire

// File: bench/dso_selector_test.sv
/*
 * Self-checking bench for the status output selector.
 * Assumes the selector, its package, checker and relay bank are compiled.
 */
`default_nettype none
module dso_selector_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dso_pkg::*;
  localparam logic [10:0] CODES [13] = '{FC_FWD_RUNNING, FC_REV_RUNNING,
    FC_REMOTE, FC_THERMISTOR, FC_ARRIVAL, FC_ANY_ALARM, FC_TORQUE_POL,
    FC_READY, FC_CUSTOM1, FC_CUSTOM1 + 11'h001, FC_CUSTOM1 + 11'h002,
    FC_CUSTOM1 + 11'h003, FC_CUSTOM5};
  logic             i_clk    = 1'b0;
  logic             i_resetn = 1'b0;
  dso_bus_req_type  bus      = '0;
  dso_drive_in_type drv      = '0;
  logic [15:0]      rdata;
  logic [4:0]       term;
  logic [4:0]       contact;
  logic             run_acc;
  dso_flags_type    fl;
  int               failures  = 0;
  int               cmp_count = 0;
  always #50 i_clk = ~i_clk;
  dso_selector #(.P_CYC_PER_MS(10)) dut_u (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_bus(bus), .o_rdata(rdata), .i_drive(drv),
    .o_term(term), .o_run_accept(run_acc), .o_flags(fl));
  dso_relay_bank relay_u (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_coil(term), .o_contact(contact));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    bus <= '0;
  endtask
  task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
    check(rdata, exp);
  endtask
  task automatic set_src(input logic [10:0] c, input logic v);
    case (c)
      FC_FWD_RUNNING: drv.forward_running_flag <= v;
      FC_REV_RUNNING: drv.reverse_running_flag <= v;
      FC_REMOTE:      drv.remote_mode_flag <= v;
      FC_THERMISTOR:  drv.thermistor_overheat_flag <= v;
      FC_ARRIVAL:     drv.arrival_window_flag <= v;
      FC_ANY_ALARM:   drv.alarm <= v;
      FC_TORQUE_POL:  drv.torque_braking <= v;
      FC_READY:       drv.hw_prep_done <= v;
      default:        drv.custom_logic_out[3'(c - FC_CUSTOM1)] <= v;
    endcase
  endtask
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #2_000_000;
    failures++;
    $display("watchdog expired");
    end_of_test();
  end
  initial begin
    drv.dc_volt <= 16'h0100;
    tick(4);
    i_resetn <= 1'b1;
    rd_check(REG_CTRL, CTRL_RST);
    rd_check(REG_START_FREQ, START_FREQ_RST);
    rd_check(REG_STOP_FREQ, STOP_FREQ_RST);
    rd_check(REG_UV_LEVEL, UV_LEVEL_RST);
    rd_check(REG_TERM_BASE, 16'(TERM_CFG_RST));
    wr(4'hF, 16'hFFFF);
    rd_check(4'hF, 16'h0000);
    $display("reset values done");
    foreach (CODES[i]) begin
      wr(REG_TERM_BASE, 16'(CODES[i]));
      wr(REG_TERM_BASE + 4'h1, 16'(CODES[i] + INV_OFFSET));
      for (int v = 0; v < 2; v++) begin
        set_src(CODES[i], v[0]);
        tick(8);
        check(16'(term[0]), 16'(v[0]));
        check(16'(term[1]), 16'(!v[0]));
        check(16'(contact[0]), 16'(v[0]));
      end
      set_src(CODES[i], 1'b0);
    end
    wr(REG_TERM_BASE + 4'h1, 16'h03F3);
    rd_check(REG_TERM_BASE + 4'h1, 16'(FC_CUSTOM5 + INV_OFFSET));
    wr(REG_TERM_BASE, 16'h03F1);
    tick(4);
    check(16'(term[0]), 16'h0000);
    wr(REG_TERM_BASE, 16'(FC_ARRIVAL));
    set_src(FC_ARRIVAL, 1'b1);
    wr(REG_CTRL, 16'(MODE_TORQUE));
    tick(4);
    check(16'(term[0]), 16'h0000);
    wr(REG_CTRL, 16'(MODE_PG));
    tick(4);
    check(16'(term[0]), 16'h0001);
    rd_check(REG_STATUS, 16'h0C00);
    $display("routing done");
    wr(REG_CTRL, 16'h0008);
    tick(3);
    check(16'(fl.keypad_source_flag), 16'h0001);
    wr(REG_CTRL, 16'(MODE_VF));
    drv.hw_prep_done <= 1'b1;
    drv.protect_active <= 1'b1;
    tick(4);
    check(16'(fl.keypad_source_flag), 16'h0000);
    check(16'(fl.ready_flag), 16'h0000);
    drv.protect_active <= 1'b0;
    drv.out_freq <= 16'h0006;
    tick(4);
    check(16'({fl.run_flag, fl.output_active_flag}), 16'h0003);
    drv.dc_braking <= 1'b1;
    tick(4);
    check(16'({fl.run_flag, fl.output_active_flag}), 16'h0001);
    drv.dc_braking <= 1'b0;
    drv.out_freq <= 16'h0003;
    tick(4);
    check(16'({fl.run_flag, fl.output_active_flag}), 16'h0003);
    drv.out_freq <= 16'h0001;
    tick(4);
    check(16'({fl.run_flag, fl.output_active_flag}), 16'h0000);
    drv.out_freq <= 16'h0006;
    drv.dew_prevent <= 1'b1;
    tick(4);
    check(16'({fl.run_flag, fl.output_active_flag}), 16'h0001);
    drv.dew_prevent <= 1'b0;
    drv.pre_exciting <= 1'b1;
    drv.out_freq <= 16'h0001;
    tick(4);
    check(16'({fl.run_flag, fl.output_active_flag}), 16'h0001);
    drv.pre_exciting <= 1'b0;
    drv.zero_speed <= 1'b1;
    wr(REG_CTRL, 16'(MODE_NO_PG));
    tick(4);
    check(16'({fl.run_flag, fl.output_active_flag}), 16'h0003);
    drv.zero_speed <= 1'b0;
    drv.servo_lock <= 1'b1;
    wr(REG_CTRL, 16'(MODE_PG));
    tick(4);
    check(16'({fl.run_flag, fl.output_active_flag}), 16'h0003);
    drv.servo_lock <= 1'b0;
    $display("run flags done");
    drv.dc_volt <= 16'h0064;
    tick(4);
    drv.forward_run_command <= 1'b1;
    tick(4);
    check(16'({fl.undervoltage_flag, run_acc}), 16'h0002);
    check(16'(fl.mains_contactor_ctrl), 16'h0000);
    drv.dc_volt <= 16'h0100;
    tick(6);
    check(16'({fl.undervoltage_flag, run_acc}), 16'h0001);
    check(16'(fl.mains_contactor_ctrl), 16'h0001);
    drv.forward_run_command <= 1'b0;
    drv.stop_cmd <= 1'b1;
    tick(4);
    check(16'(fl.mains_contactor_ctrl), 16'h0001);
    drv.motor_stopped <= 1'b1;
    tick(4);
    check(16'(fl.mains_contactor_ctrl), 16'h0000);
    drv.stop_cmd <= 1'b0;
    drv.motor_stopped <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      drv.forward_run_command <= 1'b1;
      tick(4);
      check(16'(fl.mains_contactor_ctrl), 16'h0001);
      drv.forward_run_command <= 1'b0;
      if (k == 0) drv.coast_cmd <= 1'b1;
      else drv.alarm <= 1'b1;
      tick(2);
      check(16'(fl.mains_contactor_ctrl), 16'h0000);
      drv.coast_cmd <= 1'b0;
      drv.alarm <= 1'b0;
    end
    drv.uv_trip <= 1'b1;
    tick(4);
    check(16'(fl.undervoltage_flag), 16'h0001);
    drv.uv_trip <= 1'b0;
    $display("contactor done");
    drv.limit_actions <= 4'h1;
    tick(5);
    drv.limit_actions <= 4'h0;
    tick(50);
    check(16'({fl.output_limit_flag, fl.delayed_limit_flag}), 16'h0002);
    tick(1200);
    check(16'(fl.output_limit_flag), 16'h0000);
    for (int b = 0; b < 4; b++) begin
      drv.limit_actions <= 4'(1 << b);
      tick(240);
      check(16'({fl.output_limit_flag, fl.delayed_limit_flag}), 16'h0003);
      drv.limit_actions <= 4'h0;
      tick(1200);
      check(16'(fl.delayed_limit_flag), 16'h0000);
    end
    $display("limits done");
    end_of_test();
  end
endmodule
`default_nettype wire
